// ---- hub_strap_pkg.sv ----
`default_nettype none
package hub_strap_pkg;

	// ==================================================================
	// Register map (byte addresses, one 32-bit word each)
	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 32;
	localparam int          PORTS           = 4;
	localparam logic [3:0]  CONTROL_OFS     = 4'h0;
	localparam logic [3:0]  STRAP_OFS       = 4'h4;
	localparam logic [3:0]  OVERCURRENT_OFS = 4'h8;

	// ==================================================================
	// Control fields
	localparam int CTL_HIGHSPEED_BIT = 0;
	localparam int CTL_ACTIVE_BIT    = 1;
	localparam int CTL_STRAP_EN_BIT  = 2;

	// Strap status fields
	localparam int STR_METHOD_LSB = 0;
	localparam int STR_CODE_LSB   = 2;
	localparam int STR_MASK_LSB   = 4;
	localparam int STR_RESET_BIT  = 8;

	// Over-current fields
	localparam int OC_LIVE_LSB   = 0;
	localparam int OC_STICKY_LSB = 4;

	// ==================================================================
	// Reset values
	localparam logic       STRAP_EN_RST    = 1'b1;
	localparam logic [1:0] METHOD_RST      = 2'h0;
	localparam logic [1:0] CODE_RST        = 2'h0;
	localparam logic [3:0] PORT_MASK_RST   = 4'h0;

	// ==================================================================
	// Fixed (non-removable) port code
	typedef enum logic [1:0] {
		ALL_REMOVABLE = 2'b00,
		PORT1_FIXED   = 2'b01,
		PORT12_FIXED  = 2'b10,
		PORT123_FIXED = 2'b11
	} fixed_code_t;

	function automatic logic [3:0] fixed_port_mask(input logic [1:0] code);
		case (fixed_code_t'(code))
			ALL_REMOVABLE: fixed_port_mask = 4'h0;
			PORT1_FIXED:   fixed_port_mask = 4'h1;
			PORT12_FIXED:  fixed_port_mask = 4'h3;
			PORT123_FIXED: fixed_port_mask = 4'h7;
			default:       fixed_port_mask = 4'h0;
		endcase
	endfunction

endpackage
`default_nettype wire

// ---- strap_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module strap_capture
	import hub_strap_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Chip reset pin and shared strap pins
	input  wire logic       chip_reset_n,
	input  wire logic       method_bit0,
	input  wire logic       method_bit1,
	input  wire logic       code_bit1,
	input  wire logic       code_bit0,
	input  wire logic       strap_enable,
	// Latched values
	output logic            in_reset_reg,
	output logic [1:0]      config_method_reg,
	output logic [1:0]      fixed_code_reg
);
	// ==================================================================
	// Chip reset state; starts in reset so an already high pin captures
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_reset_reg <= 1'b1;
		end else begin
			in_reset_reg <= !chip_reset_n; // R01
		end
	end

	// ==================================================================
	// Capture only on the release edge; later pin activity is ignored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			config_method_reg <= METHOD_RST;
			fixed_code_reg    <= CODE_RST;
		end else if (in_reset_reg && chip_reset_n) begin // R12
			config_method_reg <= {method_bit1, method_bit0}; // R03
			fixed_code_reg    <= strap_enable ? {code_bit1, code_bit0} : CODE_RST; // R06
		end
	end

endmodule
`default_nettype wire

// ---- indicator_driver.sv ----
`timescale 1ns/1ps
`default_nettype none
module indicator_driver (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// State to show
	input  wire logic in_reset,
	input  wire logic hs_active_low,
	input  wire logic susp_active_low,
	input  wire logic highspeed,
	input  wire logic hub_active,
	// Pin drive
	output logic      hs_out_reg,
	output logic      hs_oe_reg,
	output logic      susp_out_reg,
	output logic      susp_oe_reg
);
	// ==================================================================
	// Pins float during reset so the board straps can be sampled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hs_out_reg <= 1'b0;
			hs_oe_reg  <= 1'b0;
		end else if (in_reset) begin
			hs_out_reg <= 1'b0;
			hs_oe_reg  <= 1'b0;
		end else begin
			hs_out_reg <= highspeed ^ hs_active_low; // R04 R05
			hs_oe_reg  <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			susp_out_reg <= 1'b0;
			susp_oe_reg  <= 1'b0;
		end else if (in_reset) begin
			susp_out_reg <= 1'b0;
			susp_oe_reg  <= 1'b0;
		end else begin
			susp_out_reg <= hub_active ^ susp_active_low; // R10
			susp_oe_reg  <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// ---- hub_strap_top.sv ----
// What this block does
// R01: Device is held in reset while the chip reset pin is low.
// R02: Reset source holds the pin low at least 1 us after supplies settle.
// R03: Both configuration method pins are latched at the reset pin rising edge.
// R04: High-speed indicator is active high if method bit1 is 0, else low.
// R05: High-speed indicator asserted at high-speed upstream link, negated at full speed.
// R06: When strap enabled, both fixed port code pins are sampled at reset release.
// R07: Fixed code 00 none, 01 port 1, 10 ports 1-2, 11 ports 1-3.
// R08: One over-current sense input per port, asserted means port over-current.
// R09: Without crystal, board feeds 24 MHz clock in and leaves crystal output open.
// R10: Suspend indicator active high for codes 00 and 10, low for 01 and 11.
// R11: Signals with low suffix assert at low level, all others at high.
// R12: Latched strap values hold from reset release until the next reset.
`timescale 1ns/1ps
`default_nettype none
module hub_strap_top
	import hub_strap_pkg::*;
#(
	parameter logic STRAP_ENABLE_DEFAULT = STRAP_EN_RST
) (
	// Clock and reset
	input  wire logic                      CLOCK,
	input  wire logic                      SYS_RST,
	// Avalon-MM slave
	input  wire logic [hub_strap_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic                      AVS_READ,
	input  wire logic                      AVS_WRITE,
	input  wire logic [hub_strap_pkg::DATA_W-1:0] AVS_WRITEDATA,
	input  wire logic [3:0]                AVS_BYTEENABLE,
	output logic [hub_strap_pkg::DATA_W-1:0]      AVS_READDATA,
	output logic                           AVS_WAITREQUEST,
	// Chip reset pin
	input  wire logic                      RESET_N,
	// Strap and indicator pins
	input  wire logic                      CONFIG_METHOD_BIT0_IN,
	input  wire logic                      FIXED_PORT_CODE_BIT1_IN,
	input  wire logic                      HIGHSPEED_LINK_INDICATOR_IN,
	output logic                           HIGHSPEED_LINK_INDICATOR_OUT,
	output logic                           HIGHSPEED_LINK_INDICATOR_OE,
	input  wire logic                      SUSPEND_STATE_INDICATOR_IN,
	output logic                           SUSPEND_STATE_INDICATOR_OUT,
	output logic                           SUSPEND_STATE_INDICATOR_OE,
	// Over-current sense
	input  wire logic [hub_strap_pkg::PORTS-1:0]  OVERCURRENT_SENSE_LOW,
	// Status to the hub core
	output logic                           CHIP_IN_RESET,
	output logic [1:0]                     CONFIG_METHOD,
	output logic [1:0]                     FIXED_PORT_CODE,
	output logic [hub_strap_pkg::PORTS-1:0]       FIXED_PORT_MASK,
	output logic [hub_strap_pkg::PORTS-1:0]       OVERCURRENT
);
	import hub_strap_pkg::*;

	logic              in_reset;
	logic [1:0]        method;
	logic [1:0]        code;
	logic              highspeed_reg;
	logic              active_reg;
	logic              strap_en_reg;
	logic [PORTS-1:0]  mask_reg;
	logic [PORTS-1:0]  oc_live_reg;
	logic [PORTS-1:0]  oc_seen_reg;
	logic              wait_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic              req;
	logic              wr_take;
	logic              ctl_wr;
	logic              oc_wr;
	logic [DATA_W-1:0] rd_mux;

	// ==================================================================
	// Strap capture and indicators
	strap_capture u_capture (
		.clk               (CLOCK),
		.rst               (SYS_RST),
		.chip_reset_n      (RESET_N),
		.method_bit0       (CONFIG_METHOD_BIT0_IN),
		.method_bit1       (HIGHSPEED_LINK_INDICATOR_IN),
		.code_bit1         (FIXED_PORT_CODE_BIT1_IN),
		.code_bit0         (SUSPEND_STATE_INDICATOR_IN),
		.strap_enable      (strap_en_reg),
		.in_reset_reg      (in_reset),
		.config_method_reg (method),
		.fixed_code_reg    (code)
	);

	// Pins let go as soon as the reset pin falls, so a short pulse still samples straps
	indicator_driver u_indicators (
		.clk             (CLOCK),
		.rst             (SYS_RST),
		.in_reset        (in_reset || !RESET_N), // R01
		.hs_active_low   (method[1]),
		.susp_active_low (code[0]),
		.highspeed       (highspeed_reg),
		.hub_active      (active_reg),
		.hs_out_reg      (HIGHSPEED_LINK_INDICATOR_OUT),
		.hs_oe_reg       (HIGHSPEED_LINK_INDICATOR_OE),
		.susp_out_reg    (SUSPEND_STATE_INDICATOR_OUT),
		.susp_oe_reg     (SUSPEND_STATE_INDICATOR_OE)
	);

	assign CHIP_IN_RESET   = in_reset;
	assign CONFIG_METHOD   = method;
	assign FIXED_PORT_CODE = code;
	assign FIXED_PORT_MASK = mask_reg;
	assign OVERCURRENT     = oc_live_reg;
	assign AVS_READDATA    = rdata_reg;
	assign AVS_WAITREQUEST = wait_reg;

	// ==================================================================
	// Bus handshake: one wait cycle, then the access completes
	assign req     = AVS_READ || AVS_WRITE;
	assign wr_take = AVS_WRITE && !wait_reg && AVS_BYTEENABLE[0];
	assign ctl_wr  = wr_take && (AVS_ADDRESS == CONTROL_OFS);
	assign oc_wr   = wr_take && (AVS_ADDRESS == OVERCURRENT_OFS);

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wait_reg <= 1'b1;
		end else begin
			wait_reg <= !(req && wait_reg);
		end
	end

	always_comb begin
		rd_mux = '0;
		case (AVS_ADDRESS)
			CONTROL_OFS: begin
				rd_mux[CTL_HIGHSPEED_BIT] = highspeed_reg;
				rd_mux[CTL_ACTIVE_BIT]    = active_reg;
				rd_mux[CTL_STRAP_EN_BIT]  = strap_en_reg;
			end
			STRAP_OFS: begin
				rd_mux[STR_METHOD_LSB +: 2]   = method;
				rd_mux[STR_CODE_LSB +: 2]     = code;
				rd_mux[STR_MASK_LSB +: PORTS] = mask_reg;
				rd_mux[STR_RESET_BIT]         = in_reset;
			end
			OVERCURRENT_OFS: begin
				rd_mux[OC_LIVE_LSB +: PORTS]   = oc_live_reg;
				rd_mux[OC_STICKY_LSB +: PORTS] = oc_seen_reg;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	// Read data is loaded in the wait cycle and stands while waitrequest is low
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rdata_reg <= '0;
		end else if (AVS_READ && wait_reg) begin
			rdata_reg <= rd_mux;
		end
	end

	// ==================================================================
	// Control; link state is forgotten while the chip is in reset
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			highspeed_reg <= 1'b0;
			active_reg    <= 1'b0;
		end else if (in_reset) begin // R01
			highspeed_reg <= 1'b0;
			active_reg    <= 1'b0;
		end else if (ctl_wr) begin
			highspeed_reg <= AVS_WRITEDATA[CTL_HIGHSPEED_BIT];
			active_reg    <= AVS_WRITEDATA[CTL_ACTIVE_BIT];
		end
	end

	// Strap enable models a board setting, so chip reset keeps it
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			strap_en_reg <= STRAP_ENABLE_DEFAULT;
		end else if (ctl_wr) begin
			strap_en_reg <= AVS_WRITEDATA[CTL_STRAP_EN_BIT];
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mask_reg <= PORT_MASK_RST;
		end else begin
			mask_reg <= fixed_port_mask(code); // R07
		end
	end

	// ==================================================================
	// Over-current: live level plus sticky bits, write one to clear
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			oc_live_reg <= '0;
		end else begin
			oc_live_reg <= ~OVERCURRENT_SENSE_LOW; // R08 R11
		end
	end

	// A new event in the clearing cycle survives the clear
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			oc_seen_reg <= '0;
		end else if (oc_wr) begin
			oc_seen_reg <= (oc_seen_reg & ~AVS_WRITEDATA[OC_STICKY_LSB +: PORTS])
				| oc_live_reg; // R08
		end else begin
			oc_seen_reg <= oc_seen_reg | oc_live_reg;
		end
	end

	// ==================================================================
	// Checks
	property p_reset_entry;
		@(posedge CLOCK) disable iff (SYS_RST)
		!RESET_N |=> CHIP_IN_RESET && !HIGHSPEED_LINK_INDICATOR_OE ##1 !highspeed_reg;
	endproperty
	a_reset_entry: assert property (p_reset_entry) else $error("reset not entered"); // R01

	property p_capture;
		@(posedge CLOCK) disable iff (SYS_RST)
		(CHIP_IN_RESET && RESET_N)
		|=> CONFIG_METHOD == $past({HIGHSPEED_LINK_INDICATOR_IN, CONFIG_METHOD_BIT0_IN});
	endproperty
	a_capture: assert property (p_capture) else $error("method bits not latched"); // R03

	property p_hold;
		@(posedge CLOCK) disable iff (SYS_RST)
		(!CHIP_IN_RESET && RESET_N) |=> $stable(CONFIG_METHOD) && $stable(FIXED_PORT_CODE);
	endproperty
	a_hold: assert property (p_hold) else $error("straps changed outside reset"); // R12

	property p_hs_polarity;
		@(posedge CLOCK) disable iff (SYS_RST)
		(!CHIP_IN_RESET && !$past(CHIP_IN_RESET) && RESET_N) |=> HIGHSPEED_LINK_INDICATOR_OE
			&& HIGHSPEED_LINK_INDICATOR_OUT == ($past(highspeed_reg) ^ $past(CONFIG_METHOD[1]));
	endproperty
	a_hs_polarity: assert property (p_hs_polarity) else $error("speed indicator level"); // R04

	property p_hs_assert;
		@(posedge CLOCK) disable iff (SYS_RST)
		(!CHIP_IN_RESET && highspeed_reg && !CONFIG_METHOD[1] && RESET_N)
		|=> HIGHSPEED_LINK_INDICATOR_OUT;
	endproperty
	a_hs_assert: assert property (p_hs_assert) else $error("high speed not shown"); // R05

	property p_strap_disabled;
		@(posedge CLOCK) disable iff (SYS_RST)
		(CHIP_IN_RESET && RESET_N && !strap_en_reg) |=> FIXED_PORT_CODE == 2'h0;
	endproperty
	a_strap_disabled: assert property (p_strap_disabled) else $error("code taken when off"); // R06

	property p_mask_top;
		@(posedge CLOCK) disable iff (SYS_RST)
		(FIXED_PORT_CODE == 2'h3) ##1 (FIXED_PORT_CODE == 2'h3) |-> FIXED_PORT_MASK == 4'h7;
	endproperty
	a_mask_top: assert property (p_mask_top) else $error("code 11 mask wrong"); // R07

	property p_susp_low;
		@(posedge CLOCK) disable iff (SYS_RST)
		(!CHIP_IN_RESET && FIXED_PORT_CODE[0] && active_reg && RESET_N)
		|=> SUSPEND_STATE_INDICATOR_OE && !SUSPEND_STATE_INDICATOR_OUT;
	endproperty
	a_susp_low: assert property (p_susp_low) else $error("suspend polarity wrong"); // R10

	property p_overcurrent;
		@(posedge CLOCK) disable iff (SYS_RST)
		1'b1 |=> OVERCURRENT == ~$past(OVERCURRENT_SENSE_LOW)
			##1 (oc_seen_reg & $past(OVERCURRENT, 2)) == $past(OVERCURRENT, 2);
	endproperty
	a_overcurrent: assert property (p_overcurrent) else $error("over-current lost"); // R08

	property p_code_capture;
		@(posedge CLOCK) disable iff (SYS_RST)
		(CHIP_IN_RESET && RESET_N && strap_en_reg)
		|=> FIXED_PORT_CODE == $past({FIXED_PORT_CODE_BIT1_IN, SUSPEND_STATE_INDICATOR_IN});
	endproperty
	a_code_capture: assert property (p_code_capture) else $error("code bits not latched"); // R06

	property p_mask_one;
		@(posedge CLOCK) disable iff (SYS_RST)
		(FIXED_PORT_CODE == 2'h1) |=> FIXED_PORT_MASK == 4'h1;
	endproperty
	a_mask_one: assert property (p_mask_one) else $error("code 01 mask wrong"); // R07

	property p_mask_two;
		@(posedge CLOCK) disable iff (SYS_RST)
		(FIXED_PORT_CODE == 2'h2) |=> FIXED_PORT_MASK == 4'h3;
	endproperty
	a_mask_two: assert property (p_mask_two) else $error("code 10 mask wrong"); // R07

	property p_susp_high;
		@(posedge CLOCK) disable iff (SYS_RST)
		(!CHIP_IN_RESET && !FIXED_PORT_CODE[0] && active_reg && RESET_N)
		|=> SUSPEND_STATE_INDICATOR_OE && SUSPEND_STATE_INDICATOR_OUT;
	endproperty
	a_susp_high: assert property (p_susp_high) else $error("suspend polarity wrong"); // R10

	property p_sticky_set_wins;
		@(posedge CLOCK) disable iff (SYS_RST)
		(oc_wr && (oc_live_reg != 4'h0))
		|=> (oc_seen_reg & $past(oc_live_reg)) == $past(oc_live_reg);
	endproperty
	a_sticky_set_wins: assert property (p_sticky_set_wins) else $error("clear beat event"); // R08

	property p_bus_answer;
		@(posedge CLOCK) disable iff (SYS_RST)
		(req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing");

endmodule
`default_nettype wire

// ---- board_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module board_model (
	// Clock and reset source
	input  wire logic       clk,
	input  wire logic       reset_request,
	output logic            reset_busy,
	output logic            chip_reset_n,
	// Strap levels {method1, method0, code1, code0}
	input  wire logic [3:0] strap_levels,
	// Shared indicator and serial pins
	input  wire logic       hs_out,
	input  wire logic       hs_oe,
	input  wire logic       susp_out,
	input  wire logic       susp_oe,
	output logic            hs_pin,
	output logic            susp_pin,
	output logic            method0_pin,
	output logic            code1_pin,
	// Current monitors
	input  wire logic [3:0] overcurrent_flag,
	output logic [3:0]      sense_low
);
	logic [7:0] hold_cnt;

	initial begin
		chip_reset_n = 1'b1;
		reset_busy = 1'b0;
		hold_cnt = 8'h00;
	end

	// ==========================================
	// Reset source: 100 cycles at 100 MHz covers the 1 us minimum
	always @(posedge clk) begin
		if (reset_request) begin
			chip_reset_n <= 1'b0;
			reset_busy   <= 1'b1;
			hold_cnt     <= 8'h64;
		end else if (hold_cnt != 8'h00) begin
			hold_cnt <= hold_cnt - 8'h01;
			if (hold_cnt == 8'h01) begin
				chip_reset_n <= 1'b1;
				reset_busy   <= 1'b0;
			end
		end
	end

	// ==========================================
	// Pins: weak strap resistors lose to the device's own drive
	assign hs_pin      = hs_oe ? hs_out : strap_levels[3];
	assign susp_pin    = susp_oe ? susp_out : strap_levels[0];
	assign method0_pin = strap_levels[2];
	assign code1_pin   = strap_levels[1];
	// Monitor pulls its line low while the port draws too much
	assign sense_low   = ~overcurrent_flag;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import hub_strap_pkg::*;
	logic CLOCK = 1'b0, SYS_RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
	logic [3:0]  AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hf;
	logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
	logic        AVS_WAITREQUEST, RESET_N, hs_in, susp_in, m0_in, c1_in, in_rst;
	logic        hs_out, hs_oe, susp_out, susp_oe, busy, req = 1'b0;
	logic [1:0]  meth, code;
	logic [3:0]  straps = 4'h0, oc = 4'h0, sense_n, mask, ocv, sticky;
	logic [31:0] rng = 32'd63304;
	int          mismatches = 0, tests_run = 0, cycles = 0;

	always #5 CLOCK = ~CLOCK;

	hub_strap_top u_dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .RESET_N(RESET_N), .CONFIG_METHOD_BIT0_IN(m0_in),
		.FIXED_PORT_CODE_BIT1_IN(c1_in), .HIGHSPEED_LINK_INDICATOR_IN(hs_in),
		.HIGHSPEED_LINK_INDICATOR_OUT(hs_out), .HIGHSPEED_LINK_INDICATOR_OE(hs_oe),
		.SUSPEND_STATE_INDICATOR_IN(susp_in), .SUSPEND_STATE_INDICATOR_OUT(susp_out),
		.SUSPEND_STATE_INDICATOR_OE(susp_oe), .OVERCURRENT_SENSE_LOW(sense_n),
		.CHIP_IN_RESET(in_rst), .CONFIG_METHOD(meth), .FIXED_PORT_CODE(code),
		.FIXED_PORT_MASK(mask), .OVERCURRENT(ocv));

	board_model u_board (.clk(CLOCK), .reset_request(req), .reset_busy(busy),
		.chip_reset_n(RESET_N), .strap_levels(straps), .hs_out(hs_out), .hs_oe(hs_oe),
		.susp_out(susp_out), .susp_oe(susp_oe), .hs_pin(hs_in), .susp_pin(susp_in),
		.method0_pin(m0_in), .code1_pin(c1_in), .overcurrent_flag(oc), .sense_low(sense_n));

	// ==========================================
	// Helpers
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Ports 1..n fixed for code n
	function automatic logic [3:0] exp_mask(input logic [1:0] c);
		return (4'h1 << c) - 4'h1;
	endfunction

	task automatic end_of_test();
		$display("mismatches %0d, comparisons %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon access; the first edge keeps back-to-back calls apart
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge CLOCK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_BYTEENABLE <= be;
		AVS_READ <= !wr;
		AVS_WRITE <= wr;
		do begin
			@(posedge CLOCK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		rd = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		if (n >= 50)
			chk(1'b1, 1'b0);
	endtask

	always @(posedge CLOCK) begin
		cycles++;
		if (cycles > 8000) begin
			mismatches++;
			end_of_test();
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		logic en;
		logic [1:0] exp_m, exp_c;
		repeat (8) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		bus(1'b0, CONTROL_OFS, 32'h0, 4'hf, q); chk(q, 32'h4);
		bus(1'b0, STRAP_OFS, 32'h0, 4'hf, q); chk(q, 32'h0);
		bus(1'b0, 4'hc, 32'h0, 4'hf, q); chk(q, 32'h0);
		for (int i = 0; i < 5; i++) begin
			rng = next_rand(rng);
			en = (i < 4);
			straps <= {rng[1:0], (i < 4) ? 2'(i) : 2'b11};
			bus(1'b1, CONTROL_OFS, {29'h0, en, 2'b11}, 4'hf, q);
			@(posedge CLOCK) req <= 1'b1;
			@(posedge CLOCK) req <= 1'b0;
			repeat (40) @(negedge CLOCK);
			chk({in_rst, hs_oe, susp_oe}, 3'b100);
			for (int n = 0; n < 200 && busy; n++)
				@(negedge CLOCK);
			repeat (3) @(negedge CLOCK);
			exp_m = straps[3:2];
			exp_c = en ? straps[1:0] : 2'b00;
			chk(meth, exp_m);
			chk(code, exp_c);
			chk(mask, exp_mask(exp_c));
			bus(1'b0, CONTROL_OFS, 32'h0, 4'hf, q); chk(q, {29'h0, en, 2'b00});
			straps <= ~straps;
			repeat (3) @(negedge CLOCK);
			chk({meth, code}, {exp_m, exp_c});
			for (int k = 0; k < 4; k++) begin
				bus(1'b1, CONTROL_OFS, {29'h0, en, 2'(k)}, 4'hf, q);
				repeat (3) @(negedge CLOCK);
				chk(hs_out, k[0] ^ exp_m[1]);
				chk(susp_out, k[1] ^ exp_c[0]);
				chk({hs_oe, susp_oe}, 2'b11);
			end
			// Byte lane 0 disabled: the write must not land
			bus(1'b1, CONTROL_OFS, 32'h0, 4'he, q);
			bus(1'b0, CONTROL_OFS, 32'h0, 4'hf, q); chk(q, {29'h0, en, 2'b11});
			bus(1'b0, STRAP_OFS, 32'h0, 4'hf, q);
			chk(q, {23'h0, 1'b0, exp_mask(exp_c), exp_c, exp_m});
			bus(1'b1, CONTROL_OFS, 32'h4, 4'hf, q);
		end
		// Over-current from random monitor levels
		sticky = 4'h0;
		for (int i = 0; i < 6; i++) begin
			rng = next_rand(rng);
			@(posedge CLOCK) oc <= rng[3:0];
			repeat (3) @(negedge CLOCK);
			sticky = sticky | oc;
			chk(ocv, oc);
			bus(1'b0, OVERCURRENT_OFS, 32'h0, 4'hf, q); chk(q, {24'h0, sticky, oc});
		end
		@(posedge CLOCK) oc <= 4'h0;
		repeat (3) @(negedge CLOCK);
		bus(1'b1, OVERCURRENT_OFS, 32'hf0, 4'hf, q);
		bus(1'b0, OVERCURRENT_OFS, 32'h0, 4'hf, q); chk(q, 32'h0);
		// Clear while the fault is still live: the event must survive
		@(posedge CLOCK) oc <= 4'h5;
		repeat (3) @(negedge CLOCK);
		bus(1'b1, OVERCURRENT_OFS, 32'hf0, 4'hf, q);
		bus(1'b0, OVERCURRENT_OFS, 32'h0, 4'hf, q); chk(q, 32'h55);
		end_of_test();
	end
endmodule
`default_nettype wire
